/* File: rtl/pdec_pkg.sv */
`default_nettype none
package pdec_pkg;
    localparam int WAKE_PINS = 8;
    localparam logic [7:0] WAKE_ACTIVE_RST = 8'hff;
endpackage
`default_nettype wire

/* File: rtl/pdec_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pdec_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_reg;
    // first stage read only by the second stage
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_reg <= '0;
            q_out <= '0;
        end else begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/pdec_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pdec_top #(
    parameter int WAKE_PINS = pdec_pkg::WAKE_PINS
) (
    input wire logic CLK_IN,
    input wire logic RST_B_IN,
    input wire logic POWER_DOWN_INSTRUCTION_IN,
    input wire logic WAKE_SOURCE_SELECT_IN,
    input wire logic NMI_B_IN,
    input wire logic [WAKE_PINS-1:0] WAKE_PORT_IN,
    input wire logic [WAKE_PINS-1:0] WAKE_ENABLE_IN,
    input wire logic [WAKE_PINS-1:0] WAKE_ACTIVE_HIGH_IN,
    input wire logic NEXT_CODE_EXTERNAL_IN,
    input wire logic BUS_MULTIPLEXED_IN,
    input wire logic MEMORY_TRISTATE_WAIT_BIT_IN,
    input wire logic PREV_WRITE_EXTERNAL_IN,
    input wire logic WATCHDOG_OVERFLOW_IN,
    input wire logic IRQ_REQUEST_IN,
    input wire logic EVENT_TRANSFER_REQUEST_IN,
    output logic POWER_DOWN_OUT,
    output logic QUASI_IDLE_OUT,
    output logic FETCH_ENABLE_OUT,
    output logic IRQ_GRANT_OUT,
    output logic EVENT_TRANSFER_GRANT_OUT,
    output logic DEVICE_RESET_OUT,
    output logic INSTR_IGNORED_OUT
);
    typedef enum logic [1:0] {PDEC_RUN, PDEC_QIDLE, PDEC_PDOWN} pdec_state_e;
    typedef struct packed {
        pdec_state_e state;
        logic ignored;
        logic wdt_reset;
    } pdec_state_s;

    pdec_state_s cur_reg;
    pdec_state_s cur_next;
    logic nmi_b_sync;
    logic [WAKE_PINS-1:0] wake_sync;
    logic wake_hit;
    logic nmi_blocks;
    logic blocked;
    logic quasi_cond;

    ////////////////////////////////////////////////////////////////////////////////
    // pins cross into the cpu clock domain
    pdec_sync #(.WIDTH(1)) u_nmi_sync (
        .clk_in(CLK_IN),
        .rst_b_in(RST_B_IN),
        .d_in(NMI_B_IN),
        .q_out(nmi_b_sync)
    );
    pdec_sync #(.WIDTH(WAKE_PINS)) u_wake_sync (
        .clk_in(CLK_IN),
        .rst_b_in(RST_B_IN),
        .d_in(WAKE_PORT_IN),
        .q_out(wake_sync)
    );
    // reset clears both stages, so the interrupt pin reads low for two edges after release

    ////////////////////////////////////////////////////////////////////////////////
    // wake pin decode
    // a pin counts only when enabled and at its own active level, so idle pins never match
    function automatic logic any_wake_active(
        input logic [WAKE_PINS-1:0] pins,
        input logic [WAKE_PINS-1:0] enable,
        input logic [WAKE_PINS-1:0] active_high
    );
        return |(enable & ~(pins ^ active_high));
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // entry decision
    assign nmi_blocks = !WAKE_SOURCE_SELECT_IN && nmi_b_sync;
    assign wake_hit = any_wake_active(wake_sync, WAKE_ENABLE_IN, WAKE_ACTIVE_HIGH_IN);
    assign blocked = nmi_blocks || (WAKE_SOURCE_SELECT_IN && wake_hit);
    // the flaw of this silicon: a blocked entry can hang the fetch unit
    assign quasi_cond = NEXT_CODE_EXTERNAL_IN &&
        ((BUS_MULTIPLEXED_IN && !MEMORY_TRISTATE_WAIT_BIT_IN)
         || PREV_WRITE_EXTERNAL_IN);

    always_comb begin
        cur_next = cur_reg;
        cur_next.ignored = 1'b0;
        cur_next.wdt_reset = 1'b0;
        unique case (cur_reg.state)
            PDEC_RUN: begin
                if (POWER_DOWN_INSTRUCTION_IN) begin
                    if (!blocked) begin
                        cur_next.state = PDEC_PDOWN;
                    end else if (quasi_cond) begin
                        cur_next.state = PDEC_QIDLE;
                    end else begin
                        cur_next.ignored = 1'b1;
                    end
                end
            end
            PDEC_QIDLE: begin
                if (!nmi_b_sync) begin
                    cur_next.state = PDEC_PDOWN;
                end
            end
            PDEC_PDOWN: begin
                // leaving power-down is the job of the wake logic outside
                cur_next.state = PDEC_PDOWN;
            end
            default: begin
                // an illegal code falls back to run rather than locking the fetch unit
                cur_next.state = PDEC_RUN;
            end
        endcase
        if (WATCHDOG_OVERFLOW_IN && cur_reg.state != PDEC_PDOWN) begin
            cur_next.wdt_reset = 1'b1;
            cur_next.state = PDEC_RUN;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            cur_reg <= '{state: PDEC_RUN, ignored: 1'b0, wdt_reset: 1'b0};
        end else begin
            cur_reg <= cur_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign POWER_DOWN_OUT = cur_reg.state == PDEC_PDOWN;
    assign QUASI_IDLE_OUT = cur_reg.state == PDEC_QIDLE;
    assign FETCH_ENABLE_OUT = cur_reg.state == PDEC_RUN;
    // grants are combinational so a request is never served a cycle late
    assign IRQ_GRANT_OUT = IRQ_REQUEST_IN && cur_reg.state == PDEC_RUN;
    assign EVENT_TRANSFER_GRANT_OUT = EVENT_TRANSFER_REQUEST_IN && cur_reg.state == PDEC_RUN;
    assign DEVICE_RESET_OUT = cur_reg.wdt_reset;
    assign INSTR_IGNORED_OUT = cur_reg.ignored;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    AST_NMI_BLOCK: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        (cur_reg.state == PDEC_RUN && POWER_DOWN_INSTRUCTION_IN && nmi_blocks
         && !WATCHDOG_OVERFLOW_IN) |=> !POWER_DOWN_OUT)
        else $error("power-down entered with interrupt pin high");
    AST_WAKE_BLOCK: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        (cur_reg.state == PDEC_RUN && POWER_DOWN_INSTRUCTION_IN && WAKE_SOURCE_SELECT_IN
         && wake_hit && !WATCHDOG_OVERFLOW_IN) |=> !POWER_DOWN_OUT)
        else $error("power-down entered with wake pin active");
    AST_ENTER: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        (cur_reg.state == PDEC_RUN && POWER_DOWN_INSTRUCTION_IN && !blocked
         && !WATCHDOG_OVERFLOW_IN) |=> POWER_DOWN_OUT)
        else $error("power-down not entered");
    AST_QIDLE_MUX: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        (cur_reg.state == PDEC_RUN && POWER_DOWN_INSTRUCTION_IN && blocked
         && NEXT_CODE_EXTERNAL_IN && BUS_MULTIPLEXED_IN && !MEMORY_TRISTATE_WAIT_BIT_IN
         && !WATCHDOG_OVERFLOW_IN) |=> QUASI_IDLE_OUT)
        else $error("quasi-idle missed on mux bus");
    AST_QIDLE_WRITE: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        (cur_reg.state == PDEC_RUN && POWER_DOWN_INSTRUCTION_IN && blocked
         && NEXT_CODE_EXTERNAL_IN && PREV_WRITE_EXTERNAL_IN
         && !WATCHDOG_OVERFLOW_IN) |=> QUASI_IDLE_OUT)
        else $error("quasi-idle missed after external write");
    AST_NO_FETCH: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        QUASI_IDLE_OUT |-> !FETCH_ENABLE_OUT)
        else $error("fetch while quasi-idle");
    AST_WDT: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        (QUASI_IDLE_OUT && WATCHDOG_OVERFLOW_IN) |=> DEVICE_RESET_OUT ##1 !DEVICE_RESET_OUT
        or (DEVICE_RESET_OUT && !QUASI_IDLE_OUT))
        else $error("watchdog ignored while quasi-idle");
    AST_NO_IRQ: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        QUASI_IDLE_OUT |-> !IRQ_GRANT_OUT && !EVENT_TRANSFER_GRANT_OUT)
        else $error("service while quasi-idle");
    AST_NMI_EXIT: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        (QUASI_IDLE_OUT && !nmi_b_sync && !WATCHDOG_OVERFLOW_IN) |=> POWER_DOWN_OUT)
        else $error("no power-down from quasi-idle");
    AST_IGNORED: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        (cur_reg.state == PDEC_RUN && POWER_DOWN_INSTRUCTION_IN && blocked && !quasi_cond
         && !WATCHDOG_OVERFLOW_IN) |=> (INSTR_IGNORED_OUT && FETCH_ENABLE_OUT))
        else $error("ignored power-down did not keep running");
    AST_PDOWN_HOLD: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        POWER_DOWN_OUT |=> (POWER_DOWN_OUT && !FETCH_ENABLE_OUT))
        else $error("power-down left without reset");
    AST_PDOWN_IRQ: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        POWER_DOWN_OUT |-> (!IRQ_GRANT_OUT && !EVENT_TRANSFER_GRANT_OUT))
        else $error("service while in power-down");
    AST_QIDLE_HOLD: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        (QUASI_IDLE_OUT && nmi_b_sync && !WATCHDOG_OVERFLOW_IN) |=> QUASI_IDLE_OUT)
        else $error("quasi-idle left without interrupt pin or watchdog");
    AST_QIDLE_REFUSE: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        (QUASI_IDLE_OUT && POWER_DOWN_INSTRUCTION_IN) |=> !INSTR_IGNORED_OUT)
        else $error("instruction taken while quasi-idle");
    AST_WDT_RUN: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        (WATCHDOG_OVERFLOW_IN && !POWER_DOWN_OUT) |=> (DEVICE_RESET_OUT && FETCH_ENABLE_OUT))
        else $error("watchdog overflow did not reset");
    AST_GRANT_RUN: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        FETCH_ENABLE_OUT |-> ((IRQ_GRANT_OUT == IRQ_REQUEST_IN)
        && (EVENT_TRANSFER_GRANT_OUT == EVENT_TRANSFER_REQUEST_IN)))
        else $error("request not served while running");

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios seen

    COV_ENTER: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        !POWER_DOWN_OUT ##1 POWER_DOWN_OUT);
    COV_QIDLE: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        QUASI_IDLE_OUT ##1 POWER_DOWN_OUT);
    COV_IGNORE: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN) INSTR_IGNORED_OUT);
    COV_WDT: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        QUASI_IDLE_OUT && WATCHDOG_OVERFLOW_IN);
    COV_QIDLE_WRITE: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        QUASI_IDLE_OUT && PREV_WRITE_EXTERNAL_IN && MEMORY_TRISTATE_WAIT_BIT_IN);
endmodule
`default_nettype wire

/* File: testbench/pdec_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far side: interrupt pin and wake pins of the wake port
module pdec_far_model (
    input wire logic nmi_high_in,
    input wire logic wake_hit_in,
    input wire logic [7:0] act_in,
    output logic nmi_b_out,
    output logic [7:0] wake_out
);
    // idle pins sit at the inverse of their active level, never at a guessed 0
    assign nmi_b_out = nmi_high_in;
    assign wake_out = wake_hit_in ? (~act_in ^ 8'h08) : ~act_in;
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'h0, rst_b = 1'h0, instr = 1'h0, sel = 1'h0, nmi_high = 1'h1, hit = 1'h0;
    logic ext = 1'h0, mux = 1'h0, wt = 1'h1, pw = 1'h0, wdog = 1'h0, irq = 1'h0, evt = 1'h0;
    logic nmi_b, pd, qi, fe, ig, eg, dr, ii;
    logic [7:0] wake;
    logic [7:0] act = 8'h0f;
    int n_fail = 0;
    int checks_done = 0;
    always #4 clk = ~clk;
    pdec_far_model far (.nmi_high_in(nmi_high), .wake_hit_in(hit), .act_in(act),
        .nmi_b_out(nmi_b), .wake_out(wake));
    pdec_top dut (.CLK_IN(clk), .RST_B_IN(rst_b), .POWER_DOWN_INSTRUCTION_IN(instr),
        .WAKE_SOURCE_SELECT_IN(sel), .NMI_B_IN(nmi_b), .WAKE_PORT_IN(wake),
        .WAKE_ENABLE_IN(8'h3c), .WAKE_ACTIVE_HIGH_IN(act), .NEXT_CODE_EXTERNAL_IN(ext),
        .BUS_MULTIPLEXED_IN(mux), .MEMORY_TRISTATE_WAIT_BIT_IN(wt),
        .PREV_WRITE_EXTERNAL_IN(pw), .WATCHDOG_OVERFLOW_IN(wdog), .IRQ_REQUEST_IN(irq),
        .EVENT_TRANSFER_REQUEST_IN(evt), .POWER_DOWN_OUT(pd), .QUASI_IDLE_OUT(qi),
        .FETCH_ENABLE_OUT(fe), .IRQ_GRANT_OUT(ig), .EVENT_TRANSFER_GRANT_OUT(eg),
        .DEVICE_RESET_OUT(dr), .INSTR_IGNORED_OUT(ii));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // power-down only leaves by reset, so each scenario starts afresh
    task automatic restart();
        rst_b = 1'h0;
        cyc(2);
        rst_b = 1'h1;
        cyc(3);
    endtask
    // pins get three cycles to pass the synchronisers first
    task automatic issue(input logic s, input logic n, input logic h);
        sel = s;
        nmi_high = n;
        hit = h;
        cyc(3);
        instr = 1'h1;
        cyc(1);
        instr = 1'h0;
    endtask
    task automatic t_enter();
        restart();
        issue(1'h0, 1'h0, 1'h1);
        chk("pd", 1'h1, pd);
        chk("fetch", 1'h0, fe);
        restart();
        issue(1'h1, 1'h1, 1'h0);
        chk("pd", 1'h1, pd);
        act = 8'h00;
        restart();
        issue(1'h1, 1'h1, 1'h0);
        chk("pd", 1'h1, pd);
        act = 8'h0f;
    endtask
    task automatic t_ignore();
        restart();
        ext = 1'h0;
        mux = 1'h1;
        wt = 1'h0;
        issue(1'h0, 1'h1, 1'h0);
        chk("ign", 1'h1, ii);
        chk("pd", 1'h0, pd);
        issue(1'h1, 1'h0, 1'h1);
        chk("ign", 1'h1, ii);
        chk("qi", 1'h0, qi);
        chk("fetch", 1'h1, fe);
        act = 8'h00;
        issue(1'h1, 1'h0, 1'h1);
        chk("ign", 1'h1, ii);
        chk("pd", 1'h0, pd);
        act = 8'h0f;
    endtask
    // p=0: mux bus with wait bit 0; p=1: external write before, other bus setup
    task automatic go_quasi(input logic p);
        restart();
        ext = 1'h1;
        mux = 1'h1;
        wt = p;
        pw = p;
        irq = 1'h1;
        evt = 1'h1;
        issue(1'h0, 1'h1, 1'h0);
        chk("qi", 1'h1, qi);
        chk("fetch", 1'h0, fe);
        chk("irq", 1'h0, ig);
        chk("evt", 1'h0, eg);
    endtask
    task automatic t_quasi_wdog();
        go_quasi(1'h0);
        wdog = 1'h1;
        cyc(1);
        wdog = 1'h0;
        chk("rst", 1'h1, dr);
        chk("qi", 1'h0, qi);
        cyc(1);
        chk("rst", 1'h0, dr);
        chk("irq", 1'h1, ig);
        chk("evt", 1'h1, eg);
    endtask
    task automatic t_quasi_nmi();
        go_quasi(1'h1);
        instr = 1'h1;
        cyc(1);
        instr = 1'h0;
        chk("ign", 1'h0, ii);
        chk("qi", 1'h1, qi);
        nmi_high = 1'h0;
        cyc(2);
        chk("pd", 1'h0, pd);
        cyc(2);
        chk("pd", 1'h1, pd);
        wdog = 1'h1;
        cyc(1);
        wdog = 1'h0;
        chk("rst", 1'h0, dr);
    endtask
    task automatic give_verdict();
        if (n_fail == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        cyc(6);
        rst_b = 1'h1;
        cyc(3);
        t_enter();
        t_ignore();
        t_quasi_wdog();
        t_quasi_nmi();
        give_verdict();
    end
    // the tests need some 80 cycles
    initial begin
        #5000;
        n_fail++;
        give_verdict();
    end
endmodule
`default_nettype wire
